// File: dsf_defines.svh
// Constants for the deep synchronous FIFO with programmable flags
`ifndef DSF_DEFINES_SVH
`define DSF_DEFINES_SVH

`define DSF_DATA_W       9
`define DSF_ADDR_W       16
`define DSF_PTR_W        17
`define DSF_DEPTH        17'h10000
`define DSF_OFS_W        16
`define DSF_OFS_HI_W     7
`define DSF_OFS_DEFAULT  16'h0007
`define DSF_OFS_LO_RST   9'h007
`define DSF_OFS_HI_RST   9'h000
`define DSF_FLAGS_RST    4'b1100
`define DSF_SEQ_EMPTY_LO 2'h0
`define DSF_SEQ_EMPTY_HI 2'h1
`define DSF_SEQ_FULL_LO  2'h2
`define DSF_SEQ_FULL_HI  2'h3
`define DSF_LOCK_CNT     2'h3
`define DSF_SYNC_STAGES  2

`endif

// File: dsf_pkg.sv
// Types shared by the deep synchronous FIFO design
package dsf_pkg;

  typedef enum logic [2:0] {
    DSF_MODE_WAIT = 3'b001,
    DSF_MODE_PROG = 3'b010,
    DSF_MODE_CASC = 3'b100
  } dsf_mode_type;

  typedef struct packed {
    logic       wclk;
    logic       rclk;
    logic       wen_n;
    logic       ren_n;
    logic       ld_n;
    logic       oe_n;
    logic       rt;
    logic [8:0] din;
  } dsf_pins_type;

  typedef struct packed {
    logic full_n;
    logic almost_full_n;
    logic almost_empty_n;
    logic empty_n;
  } dsf_flags_type;

  typedef struct packed {
    logic        en;
    logic [15:0] addr;
    logic [8:0]  data;
  } dsf_wr_type;

  typedef struct packed {
    dsf_pins_type  prev;
    dsf_mode_type  mode;
    logic [1:0]    lock_cnt;
    logic [16:0]   wr_ptr;
    logic [16:0]   rd_ptr;
    logic [8:0]    ofs_e_lo;
    logic [8:0]    ofs_e_hi;
    logic [8:0]    ofs_f_lo;
    logic [8:0]    ofs_f_hi;
    logic [1:0]    seq;
    dsf_flags_type flags;
    logic [8:0]    dout;
    logic          oe_n;
    logic          token;
    logic          xo_n;
  } dsf_state_type;

endpackage

// File: dsf_sync.sv
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/1ps
module dsf_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys_i,  // System clock
  input  wire logic         reset_n_i,  // Async reset, active low
  input  wire logic [W-1:0] async_i,    // Raw pin levels
  output logic      [W-1:0] sync_o      // Levels after two flops
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } dsf_sync_state_type;

  dsf_sync_state_type st_ff;
  dsf_sync_state_type nxt_st;

  always_comb begin
    nxt_st.meta   = async_i;
    nxt_st.stable = st_ff.meta;
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign sync_o = st_ff.stable;

endmodule // dsf_sync

// File: dsf_mem.sv
// Flip-flop storage array of the FIFO, one write and one read port
`timescale 1ns/1ps
module dsf_mem
  import dsf_pkg::*;
(
  input  wire logic             clk_sys_i,  // System clock
  input  dsf_pkg::dsf_wr_type   wr_i,       // Write enable, address, data
  input  wire logic [15:0]      raddr_i,    // Read address
  output logic      [8:0]       rdata_o     // Word at read address
);

  // Storage holds no reset: contents are only valid behind the pointers
  logic [8:0] mem_ff [0:65535];

  always_ff @(posedge clk_sys_i) begin
    if (wr_i.en) begin
      mem_ff[wr_i.addr] <= wr_i.data;
    end
  end

  assign rdata_o = mem_ff[raddr_i];

endmodule // dsf_mem

// File: dsf_fifo.sv
// Deep synchronous FIFO core with programmable flags and retransmit
`timescale 1ns/1ps
`include "dsf_defines.svh"
// Contract
// - Write enabled, not full: store input word
// - Read enabled, not empty: present next word
// - Output enable high floats data outputs
// - Only read-token holder drives shared outputs
// - Ignore writes when full, reads when empty
// - Empty FIFO keeps last read word
// - Load low at reset selects programmable mode
// - Load writes rotate through four offset registers
// - Load high resumes FIFO, sequence kept
// - Load reads rotate through offsets likewise
// - Almost-empty low at count <= n
// - Almost-full low at count >= depth-m
// - Retransmit only outside depth cascade
// - Retransmit pulse rewinds read pointer only
// - After retransmit, reads replay up to writer
// - Retransmit recomputes all flags
// - Reset empties FIFO, clears outputs
// - Default offsets are seven
// - Empty flags on read edges, full on write
module dsf_fifo
  import dsf_pkg::*;
(
  input  wire logic       clk_sys_i,          // System clock, 50 MHz
  input  wire logic       reset_n_i,          // Master reset, active low
  input  wire logic       write_clk_i,        // Write clock pin
  input  wire logic       read_clk_i,         // Read clock pin
  input  wire logic       write_en_n_i,       // Write enable, active low
  input  wire logic       read_en_n_i,        // Read enable, active low
  input  wire logic       offset_load_n_i,    // Load, or expansion_in_n
  input  wire logic       output_en_n_i,      // Output enable, active low
  input  wire logic       retransmit_strobe_i,// Retransmit, or first_load_n
  input  wire logic [8:0] data_in_i,          // Input word
  output logic      [8:0] data_out_o,         // Output register
  output logic            data_out_oe_n_o,    // Low while outputs drive
  output logic            empty_flag_n_o,     // Empty, active low
  output logic            full_flag_n_o,      // Full, active low
  output logic            almost_empty_flag_n_o, // Almost empty, low
  output logic            almost_full_flag_n_o   // Almost full, or xo_n
);
  import dsf_pkg::*;

  dsf_state_type st_ff;
  dsf_state_type nxt_st;
  dsf_pins_type  raw_pins;
  dsf_pins_type  sy;
  dsf_wr_type    mem_wr;
  logic [8:0]    mem_rdata;

  logic          wr_edge;
  logic          rd_edge;
  logic          rt_edge;
  logic          load_sel;
  logic          normal;
  logic          wr_load;
  logic          rd_load;
  logic          wr_data;
  logic          rd_data;
  logic          xi_fall;
  logic [16:0]   nxt_cnt;

  function automatic logic [15:0] ofs_join(input logic [8:0] lo,
                                           input logic [8:0] hi);
    ofs_join = {hi[`DSF_OFS_HI_W-1:0], lo};
  endfunction

  function automatic logic [16:0] word_cnt(input logic [16:0] wp,
                                           input logic [16:0] rp);
    word_cnt = wp - rp;
  endfunction

  always_comb begin
    raw_pins.wclk  = write_clk_i;
    raw_pins.rclk  = read_clk_i;
    raw_pins.wen_n = write_en_n_i;
    raw_pins.ren_n = read_en_n_i;
    raw_pins.ld_n  = offset_load_n_i;
    raw_pins.oe_n  = output_en_n_i;
    raw_pins.rt    = retransmit_strobe_i;
    raw_pins.din   = data_in_i;
  end

  // Pins carry all control and data together so edges and data align
  dsf_sync #(
    .W ($bits(dsf_pins_type))
  ) u_sync (
    .clk_sys_i (clk_sys_i),
    .reset_n_i (reset_n_i),
    .async_i   (raw_pins),
    .sync_o    (sy)
  );

  dsf_mem u_mem (
    .clk_sys_i (clk_sys_i),
    .wr_i      (mem_wr),
    .raddr_i   (st_ff.rd_ptr[`DSF_ADDR_W-1:0]),
    .rdata_o   (mem_rdata)
  );

  assign wr_edge  = sy.wclk & ~st_ff.prev.wclk;
  assign rd_edge  = sy.rclk & ~st_ff.prev.rclk;
  assign normal   = (st_ff.mode != DSF_MODE_WAIT);
  assign load_sel = (st_ff.mode == DSF_MODE_PROG) & ~sy.ld_n;
  // Retransmit pin is first_load_n when cascaded, so gate by mode
  assign rt_edge  = (st_ff.mode == DSF_MODE_PROG) & sy.rt
                    & ~st_ff.prev.rt;
  assign wr_load  = wr_edge & ~sy.wen_n & load_sel;
  assign rd_load  = rd_edge & ~sy.ren_n & load_sel;
  assign wr_data  = wr_edge & ~sy.wen_n & ~load_sel & normal
                    & st_ff.flags.full_n;
  assign rd_data  = rd_edge & ~sy.ren_n & ~load_sel & normal
                    & st_ff.flags.empty_n & st_ff.token;
  assign xi_fall  = (st_ff.mode == DSF_MODE_CASC) & ~sy.ld_n
                    & st_ff.prev.ld_n;

  always_comb begin
    nxt_st      = st_ff;
    nxt_st.prev = sy;
    nxt_st.xo_n = 1'b1;
    mem_wr.en   = 1'b0;
    mem_wr.addr = st_ff.wr_ptr[`DSF_ADDR_W-1:0];
    mem_wr.data = sy.din;

    // Mode strap is taken a few cycles after release, once synced
    case (st_ff.mode)
      DSF_MODE_WAIT: begin
        nxt_st.lock_cnt = st_ff.lock_cnt + 2'h1;
        if (st_ff.lock_cnt == `DSF_LOCK_CNT) begin
          if (sy.ld_n) begin
            nxt_st.mode  = DSF_MODE_CASC;
            nxt_st.token = ~sy.rt;
          end else begin
            nxt_st.mode  = DSF_MODE_PROG;
            nxt_st.token = 1'b1;
          end
        end
      end
      DSF_MODE_PROG, DSF_MODE_CASC: begin
        nxt_st.lock_cnt = st_ff.lock_cnt;
      end
      default: begin
        nxt_st.mode = DSF_MODE_WAIT;
      end
    endcase

    if (wr_load) begin
      case (st_ff.seq)
        `DSF_SEQ_EMPTY_LO: nxt_st.ofs_e_lo = sy.din;
        `DSF_SEQ_EMPTY_HI: nxt_st.ofs_e_hi = sy.din;
        `DSF_SEQ_FULL_LO:  nxt_st.ofs_f_lo = sy.din;
        default:           nxt_st.ofs_f_hi = sy.din;
      endcase
    end

    if (rd_load) begin
      case (st_ff.seq)
        `DSF_SEQ_EMPTY_LO: nxt_st.dout = st_ff.ofs_e_lo;
        `DSF_SEQ_EMPTY_HI: nxt_st.dout = st_ff.ofs_e_hi;
        `DSF_SEQ_FULL_LO:  nxt_st.dout = st_ff.ofs_f_lo;
        default:           nxt_st.dout = st_ff.ofs_f_hi;
      endcase
    end

    // Sequence survives load going high; both accesses advance it
    nxt_st.seq = st_ff.seq + {1'b0, wr_load} + {1'b0, rd_load};

    if (wr_data) begin
      mem_wr.en     = 1'b1;
      nxt_st.wr_ptr = st_ff.wr_ptr + 17'h1;
    end

    // With no valid read the output register simply holds
    if (rd_data) begin
      nxt_st.dout   = mem_rdata;
      nxt_st.rd_ptr = st_ff.rd_ptr + 17'h1;
    end

    if (rt_edge) begin
      nxt_st.rd_ptr = '0;
    end

    nxt_cnt = word_cnt(nxt_st.wr_ptr, nxt_st.rd_ptr);

    if (rd_edge | rt_edge) begin
      nxt_st.flags.empty_n        = (nxt_cnt != 17'h0);
      nxt_st.flags.almost_empty_n =
        (nxt_cnt > {1'b0, ofs_join(st_ff.ofs_e_lo, st_ff.ofs_e_hi)});
    end
    if (wr_edge | rt_edge) begin
      nxt_st.flags.full_n        = (nxt_cnt != `DSF_DEPTH);
      nxt_st.flags.almost_full_n = (nxt_cnt < (`DSF_DEPTH
        - {1'b0, ofs_join(st_ff.ofs_f_lo, st_ff.ofs_f_hi)}));
    end

    // Read token moves down the chain once this device runs dry
    if (st_ff.mode == DSF_MODE_CASC) begin
      if (st_ff.token & rd_data & (nxt_cnt == 17'h0)) begin
        nxt_st.token = 1'b0;
        nxt_st.xo_n  = 1'b0;
      end else if (xi_fall) begin
        nxt_st.token = 1'b1;
      end
    end

    nxt_st.oe_n = ~(~sy.oe_n & nxt_st.token);
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_ff          <= '0;
      st_ff.mode     <= DSF_MODE_WAIT;
      st_ff.ofs_e_lo <= `DSF_OFS_LO_RST;
      st_ff.ofs_e_hi <= `DSF_OFS_HI_RST;
      st_ff.ofs_f_lo <= `DSF_OFS_LO_RST;
      st_ff.ofs_f_hi <= `DSF_OFS_HI_RST;
      st_ff.seq      <= `DSF_SEQ_EMPTY_LO;
      // Empty and almost empty low, full and almost full high
      st_ff.flags    <= `DSF_FLAGS_RST;
      st_ff.oe_n     <= 1'b1;
      st_ff.xo_n     <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign data_out_o            = st_ff.dout;
  assign data_out_oe_n_o       = st_ff.oe_n;
  assign empty_flag_n_o        = st_ff.flags.empty_n;
  assign full_flag_n_o         = st_ff.flags.full_n;
  assign almost_empty_flag_n_o = st_ff.flags.almost_empty_n;
  // Dual pin: expansion output when cascaded
  assign almost_full_flag_n_o  = (st_ff.mode == DSF_MODE_CASC) ?
                                 st_ff.xo_n : st_ff.flags.almost_full_n;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!reset_n_i);

  sequence s_wr_full;
    wr_edge && !sy.wen_n && !load_sel && !st_ff.flags.full_n;
  endsequence

  AST_WRITE_STORES: assert property (wr_data |=>
    st_ff.wr_ptr == $past(st_ff.wr_ptr) + 17'h1)
    else $error("write did not advance write pointer");

  AST_READ_PRESENTS: assert property (rd_data |=>
    st_ff.dout == $past(mem_rdata))
    else $error("read did not present stored word");

  AST_OE_TOKEN: assert property (!st_ff.token |-> st_ff.oe_n)
    else $error("outputs driven without read token");

  AST_FULL_BLOCKS: assert property (s_wr_full |=>
    $stable(st_ff.wr_ptr))
    else $error("write accepted while full");

  AST_EMPTY_HOLDS: assert property ((rd_edge && !load_sel
    && !st_ff.flags.empty_n && !rt_edge) |=> $stable(st_ff.dout))
    else $error("empty FIFO changed output");

  AST_SEQ_WRAP: assert property ((wr_load && !rd_load
    && st_ff.seq == `DSF_SEQ_FULL_HI) |=>
    st_ff.seq == `DSF_SEQ_EMPTY_LO)
    else $error("offset sequence did not wrap");

  AST_RT_REWIND: assert property (rt_edge |=>
    st_ff.rd_ptr == 17'h0 && $stable(st_ff.wr_ptr))
    else $error("retransmit pointer handling wrong");

  AST_EMPTY_COUNT: assert property (rd_edge |=>
    st_ff.flags.empty_n == (st_ff.wr_ptr != st_ff.rd_ptr))
    else $error("empty flag disagrees with count");

  AST_EMPTY_DOMAIN: assert property ((!rd_edge && !rt_edge) |=>
    $stable(st_ff.flags.empty_n) && $stable(st_ff.flags.almost_empty_n))
    else $error("empty flags moved without read edge");

  AST_FULL_DOMAIN: assert property ((!wr_edge && !rt_edge) |=>
    $stable(st_ff.flags.full_n) && $stable(st_ff.flags.almost_full_n))
    else $error("full flags moved without write edge");

  AST_WAIT_SEQ: assert property ((st_ff.mode == DSF_MODE_WAIT) |->
    st_ff.seq == `DSF_SEQ_EMPTY_LO && st_ff.wr_ptr == 17'h0)
    else $error("reset state not restored");

endmodule // dsf_fifo

// File: dsf_ctrl_model.sv
// Writer and reader logic that drives the FIFO pins
`timescale 1ns/1ps
module dsf_ctrl_model (
  input  wire logic       clk_sys_i,  // System clock
  output logic            wclk_o,     // Write clock pin
  output logic            rclk_o,     // Read clock pin
  output logic            wen_n_o,    // Write enable, active low
  output logic            ren_n_o,    // Read enable, active low
  output logic            load_n_o,   // Offset load, active low
  output logic            rt_o,       // Retransmit strobe
  output logic      [8:0] din_o       // Write word
);
  // Load starts low so the device straps into programmable mode
  initial begin
    wclk_o   = 1'b0;
    rclk_o   = 1'b0;
    wen_n_o  = 1'b1;
    ren_n_o  = 1'b1;
    load_n_o = 1'b0;
    rt_o     = 1'b0;
    din_o    = 9'h000;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  // Pins pass two sync flops, so controls hold well past the clock rise
  task automatic wr(input logic [8:0] d);
    wen_n_o = 1'b0;
    din_o   = d;
    step(4);
    wclk_o  = 1'b1;
    step(6);
    wclk_o  = 1'b0;
    wen_n_o = 1'b1;
    din_o   = ~d;  // Released bus must not show a stale word
    step(4);
  endtask
  // One task at a time, so offset writes and reads never coincide
  task automatic rd(input logic en);
    ren_n_o = ~en;
    step(4);
    rclk_o  = 1'b1;
    step(6);
    rclk_o  = 1'b0;
    ren_n_o = 1'b1;
    step(4);
  endtask
  task automatic load(input logic v);
    load_n_o = v;
    step(4);
  endtask
  // Both pin clocks stay idle through the pulse and its recovery
  task automatic rt_pulse();
    rt_o = 1'b1;
    step(4);
    rt_o = 1'b0;
    step(6);
  endtask
endmodule // dsf_ctrl_model

// File: test_deep_sync_fifo_prog_flags.sv
// Self-checking bench for the deep synchronous FIFO
`timescale 1ns/1ps
`define CHECK(got, exp) begin tests_run++; if ((got) !== (exp)) begin \
  $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); \
  n_errors++; end end
module test_deep_sync_fifo_prog_flags;
  import dsf_pkg::*;
  logic       clk_sys_i;
  logic       reset_n_i;
  logic       output_en_n_i;
  wire logic       wclk;
  wire logic       rclk;
  wire logic       wen_n;
  wire logic       ren_n;
  wire logic       load_n;
  wire logic       rt;
  wire logic [8:0] din;
  wire logic [8:0] dout;
  wire logic [8:0] q;
  wire logic       oe_n;
  wire logic       ef_n;
  wire logic       ff_n;
  wire logic       ae_n;
  wire logic       af_n;
  int         n_xo_low  = 0;
  int         n_errors  = 0;
  int         tests_run = 0;
  logic [8:0] w   [4] = '{9'h1A5, 9'h05A, 9'h100, 9'h0FF};
  logic [8:0] ofs [4] = '{9'h003, 9'h000, 9'h005, 9'h000};
  logic [8:0] dfl [4] = '{9'h007, 9'h000, 9'h007, 9'h000};

  assign q = oe_n ? {9{1'bz}} : dout;

  dsf_fifo u_dsf_fifo (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .write_clk_i(wclk), .read_clk_i(rclk),
    .write_en_n_i(wen_n), .read_en_n_i(ren_n),
    .offset_load_n_i(load_n), .output_en_n_i(output_en_n_i),
    .retransmit_strobe_i(rt), .data_in_i(din),
    .data_out_o(dout), .data_out_oe_n_o(oe_n),
    .empty_flag_n_o(ef_n), .full_flag_n_o(ff_n),
    .almost_empty_flag_n_o(ae_n), .almost_full_flag_n_o(af_n)
  );

  dsf_ctrl_model u_dsf_ctrl_model (
    .clk_sys_i(clk_sys_i), .wclk_o(wclk), .rclk_o(rclk),
    .wen_n_o(wen_n), .ren_n_o(ren_n), .load_n_o(load_n),
    .rt_o(rt), .din_o(din)
  );

  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  // Expansion pulse is one cycle wide: count low cycles away from the edge
  always @(negedge clk_sys_i) begin
    if (af_n === 1'b0) begin
      n_xo_low++;
    end
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask

  // No pin clock moves while reset is low
  task automatic do_reset();
    reset_n_i = 1'b0;
    step(20);
    `CHECK(ef_n, 1'b0)
    `CHECK(ae_n, 1'b0)
    `CHECK(ff_n, 1'b1)
    `CHECK(af_n, 1'b1)
    `CHECK(dout, 9'h000)
    reset_n_i = 1'b1;
    step(10);
  endtask

  task automatic read_offsets(input logic [8:0] e [4]);
    for (int i = 0; i < 4; i++) begin
      u_dsf_ctrl_model.rd(1'b1);
      `CHECK(dout, e[i])
    end
  endtask

  initial begin
    reset_n_i     = 1'b0;
    output_en_n_i = 1'b0;
    do_reset();
    // Two writes, leave load, return: sequence must continue at full low
    u_dsf_ctrl_model.wr(ofs[0]);
    u_dsf_ctrl_model.wr(ofs[1]);
    u_dsf_ctrl_model.load(1'b1);
    u_dsf_ctrl_model.load(1'b0);
    u_dsf_ctrl_model.wr(ofs[2]);
    u_dsf_ctrl_model.wr(ofs[3]);
    u_dsf_ctrl_model.load(1'b1);
    u_dsf_ctrl_model.load(1'b0);
    read_offsets(ofs);
    u_dsf_ctrl_model.load(1'b1);
    end_test("offsets");
    u_dsf_ctrl_model.wr(w[0]);
    `CHECK(ef_n, 1'b0)
    u_dsf_ctrl_model.wr(w[1]);
    u_dsf_ctrl_model.wr(w[2]);
    u_dsf_ctrl_model.rd(1'b0);
    `CHECK(ef_n, 1'b1)
    `CHECK(ae_n, 1'b0)
    u_dsf_ctrl_model.wr(w[3]);
    u_dsf_ctrl_model.rd(1'b0);
    `CHECK(ae_n, 1'b1)
    `CHECK(af_n, 1'b1)
    `CHECK(ff_n, 1'b1)
    end_test("flags");
    for (int i = 0; i < 4; i++) begin
      u_dsf_ctrl_model.rd(1'b1);
      `CHECK(dout, w[i])
    end
    `CHECK(ef_n, 1'b0)
    u_dsf_ctrl_model.rd(1'b1);
    `CHECK(dout, w[3])
    end_test("stream");
    u_dsf_ctrl_model.rt_pulse();
    `CHECK(ef_n, 1'b1)
    `CHECK(ae_n, 1'b1)
    u_dsf_ctrl_model.wr(9'h0C3);
    for (int i = 0; i < 4; i++) begin
      u_dsf_ctrl_model.rd(1'b1);
      `CHECK(dout, w[i])
    end
    u_dsf_ctrl_model.rd(1'b1);
    `CHECK(dout, 9'h0C3)
    `CHECK(ef_n, 1'b0)
    end_test("retransmit");
    output_en_n_i = 1'b1;
    step(6);
    `CHECK(q, {9{1'bz}})
    output_en_n_i = 1'b0;
    step(6);
    `CHECK(q, 9'h0C3)
    end_test("output_enable");
    // Full depth is 65536 words: too long to fill within the run budget
    u_dsf_ctrl_model.load(1'b0);
    do_reset();
    read_offsets(dfl);
    end_test("defaults");
    // Lone device in a ring: first_load_n low, its flags are the composites
    u_dsf_ctrl_model.load(1'b1);
    do_reset();
    `CHECK(oe_n, 1'b0)
    u_dsf_ctrl_model.wr(9'h155);
    u_dsf_ctrl_model.rd(1'b0);
    u_dsf_ctrl_model.rd(1'b1);
    `CHECK(dout, 9'h155)
    `CHECK(ef_n, 1'b0)
    `CHECK(oe_n, 1'b1)
    `CHECK(n_xo_low, 1)
    // Retransmit pin is first_load_n here and must not rewind
    u_dsf_ctrl_model.rt_pulse();
    u_dsf_ctrl_model.wr(9'h0AA);
    u_dsf_ctrl_model.rd(1'b0);
    u_dsf_ctrl_model.rd(1'b1);
    `CHECK(dout, 9'h155)
    `CHECK(ef_n, 1'b1)
    u_dsf_ctrl_model.load(1'b0);
    `CHECK(oe_n, 1'b0)
    u_dsf_ctrl_model.rd(1'b1);
    `CHECK(dout, 9'h0AA)
    `CHECK(n_xo_low, 2)
    `CHECK(ff_n, 1'b1)
    end_test("cascade");
    stop_test();
  end

  initial begin
    repeat (20000) @(posedge clk_sys_i);
    n_errors++;
    $display("watchdog expired");
    stop_test();
  end
endmodule // test_deep_sync_fifo_prog_flags
